// File: inc/scsi_phase_pkg.sv
// Register map, field positions and carrier types of the SCSI phase core
//
// Overview of operation
// - Watched busy loss raises an interrupt
// - Busy loss clears control bits 5..0, releases bus
// - DMA bit precedes strobes; core handshakes itself
// - DMA bit survives transfer end
// - Arbitrate waits bus free, reports outcome
// - Target phase lines driven only in target role
// - Initiator DMA phase mismatch on request interrupts
// - Initiator flags final byte actually sent
// - Phase bits decode to six bus phases
// - Live bus register shows control lines
// - Masked ID with selection raises interrupt
// - High ID mask extends selection matching
// - High ID register shows live high lines
// - Parity checked during selection and receive
// - DMA finished flag clears with DMA bit
// - Parity fault latched only when checking enabled
// - Clear strobe read clears three flags
// - Phase equal flag tracks bus continuously
// - Busy loss sets flag, kills outputs, DMA
// - Strobes start send or role-matched receive
// - Target role bit gates driven signals
// - Parity check enable latches or ignores errors
`default_nettype none

package scsi_phase_pkg;

  localparam int          ADDR_W        = 18;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_OUT_BYTE  = 16'hfc00;
  localparam logic [15:0] IDX_INIT_CTRL = 16'hfc01;
  localparam logic [15:0] IDX_MODE      = 16'hfc02;
  localparam logic [15:0] IDX_TPHASE    = 16'hfc03;
  localparam logic [15:0] IDX_LIVE_BUS  = 16'hfc04;
  localparam logic [15:0] IDX_FLAGS     = 16'hfc05;
  localparam logic [15:0] IDX_TGT_RX    = 16'hfc06;
  localparam logic [15:0] IDX_CLR       = 16'hfc07;
  localparam logic [15:0] IDX_HIGH_ID   = 16'hfc08;
  localparam logic [15:0] IDX_HIGH_MASK = 16'hfc0c;

  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [7:0]  MODE_WMASK    = 8'hf7;
  localparam logic [3:0]  TPHASE_RESET  = 4'h0;
  localparam logic [5:0]  CTRL_RESET    = 6'h00;

  // Mode fields
  localparam int MODE_TGT = 6;
  localparam int MODE_PCHK = 5;
  localparam int MODE_EPI = 4;
  localparam int MODE_WATCH = 2;
  localparam int MODE_DMA = 1;
  localparam int MODE_ARB = 0;
  // Initiator control fields (4..0 index stored bits 4..0; 7..5 are register bit positions)
  localparam int CTRL_ACK = 4;
  localparam int CTRL_BSY = 3;
  localparam int CTRL_SEL = 2;
  localparam int CTRL_ATN = 1;
  localparam int CTRL_DRV = 0;
  localparam int CTRL_RST = 7;
  localparam int CTRL_ARBON = 6;
  localparam int CTRL_LOST  = 5;
  // Target phase fields
  localparam int TP_FINAL = 7;
  localparam int TP_REQ   = 3;
  // Flag register fields
  localparam int FL_DONE  = 7;
  localparam int FL_PFLT  = 5;
  localparam int FL_INT   = 4;
  localparam int FL_PEQ   = 3;
  localparam int FL_BLOSS = 2;
  localparam int FL_ATN   = 1;
  localparam int FL_ACK   = 0;
  localparam int HID_LSB  = 5;

  typedef enum logic [2:0] {
    PH_DATA_OUT = 3'b000,
    PH_COMMAND  = 3'b010,
    PH_MSG_OUT  = 3'b110,
    PH_DATA_IN  = 3'b001,
    PH_STATUS   = 3'b011,
    PH_MSG_IN   = 3'b111
  } phase_t;

  // Bus lines as seen, active high (true = asserted on the wire)
  typedef struct packed {
    logic       rst;
    logic       bsy;
    logic       req;
    logic       msg;
    logic       cd;
    logic       io;
    logic       sel;
    logic       dbp;
    logic       atn;
    logic       ack;
    logic [7:0] db;
    logic [2:0] hid;
  } scsi_in_t;

  // Output enables: high means the core asserts that line
  typedef struct packed {
    logic rst;
    logic bsy;
    logic sel;
    logic atn;
    logic ack;
    logic req;
    logic msg;
    logic cd;
    logic io;
    logic db;
  } scsi_oe_t;

  function automatic logic phase_defined(input logic [2:0] p);
    logic ok;
    ok = 1'b0;
    case (p)
      PH_DATA_OUT, PH_COMMAND, PH_MSG_OUT,
      PH_DATA_IN, PH_STATUS, PH_MSG_IN: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : phase_defined

endpackage : scsi_phase_pkg

`default_nettype wire

// File: hw/scsi_bus_phase_control.sv
// SCSI bus phase control core with APB register access
//
// Added by the designer: register access over APB.
`default_nettype none

module scsi_bus_phase_control
  import scsi_phase_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire scsi_in_t          bus_in,
  output scsi_oe_t               bus_oe,
  output var  logic [7:0]        bus_db_out,
  output var  logic              bus_dbp_out,
  input  wire logic              dma_tx_valid,
  input  wire logic [7:0]        dma_tx_data,
  input  wire logic              dma_last,
  output logic                   dma_tx_ready,
  output var  logic              dma_rx_valid,
  output var  logic [7:0]        dma_rx_data,
  output var  logic              irq
);

  typedef enum logic [1:0] {ARB_OFF, ARB_WAIT, ARB_ON} arb_t;
  typedef enum logic [1:0] {X_IDLE, X_LOAD, X_HOLD, X_TAIL} xfer_t;

  typedef struct packed {
    logic [7:0]  out_byte;
    logic        ctrl_rst;
    logic        arb_lost;
    logic [4:0]  ctrl;
    logic [7:0]  mode;
    logic [3:0]  tphase;
    logic        final_sent;
    logic [7:0]  sel_mask;
    logic [2:0]  hid_mask;
    logic        dma_finished_flag;
    logic        parity_fault_flag;
    logic        interrupt_active_flag;
    logic        busy_loss_flag;
    logic        bsy_q;
    logic        req_q;
    logic        selm_q;
    arb_t        arbitrate_bit;
    xfer_t       xf;
    logic        x_send;
    logic        x_tgt;
    logic        x_last;
    logic        own;
    logic [7:0]  x_byte;
    logic [31:0] rdata;
    logic        rx_valid;
    logic [7:0]  rx_data;
  } st_t;

  st_t s, next_s;

  logic        setup, acc, hit, peq, bsy_fall, selm, bad_par, known_ph;
  logic        tgt, start_ok, busy_evt, mode_wr, send_go;
  logic [15:0] idx;
  logic [7:0]  rd;

  function automatic logic [15:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction : reg_index

  // Misaligned or unmapped words answer with an error, never a side effect
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    logic [15:0] i;
    i = reg_index(a);
    return (a[1:0] == 2'b00) && (i >= IDX_OUT_BYTE)
        && ((i <= IDX_HIGH_ID) || (i == IDX_HIGH_MASK));
  endfunction : reg_mapped

  // Zero wait states; read data is already in its flop by the access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~reg_mapped(paddr);

  always_comb begin
    next_s       = s;
    dma_tx_ready = 1'b0;
    setup    = psel & ~penable;
    acc      = psel & penable;
    idx      = reg_index(paddr);
    hit      = reg_mapped(paddr);
    tgt      = s.mode[MODE_TGT];
    peq      = ({bus_in.msg, bus_in.cd, bus_in.io} == s.tphase[2:0]);
    known_ph = phase_defined(s.tphase[2:0]);
    bsy_fall = s.bsy_q & ~bus_in.bsy;
    busy_evt = s.mode[MODE_WATCH] & bsy_fall;
    // Odd parity over data plus parity line
    bad_par  = ~^{bus_in.db, bus_in.dbp};
    selm = ~bus_in.bsy & bus_in.sel
         & ((|(bus_in.db & s.sel_mask))
         |  (|(bus_in.hid & s.hid_mask)));
    mode_wr  = acc & pwrite & hit & (idx == IDX_MODE);
    start_ok = acc & pwrite & hit & s.mode[MODE_DMA];
    send_go  = start_ok & (idx == IDX_FLAGS);
    next_s.bsy_q    = bus_in.bsy;
    next_s.req_q    = bus_in.req;
    next_s.selm_q   = selm;
    next_s.rx_valid = 1'b0;

    rd = 8'h00;
    case (idx)
      IDX_OUT_BYTE:  rd = bus_in.db;
      IDX_INIT_CTRL: rd = {s.ctrl_rst, s.arbitrate_bit == ARB_ON, s.arb_lost, s.ctrl};
      IDX_MODE:      rd = s.mode;
      IDX_TPHASE:    rd = {s.final_sent, 3'b000, s.tphase};
      IDX_LIVE_BUS:  rd = {bus_in.rst, bus_in.bsy, bus_in.req, bus_in.msg,
                           bus_in.cd, bus_in.io, bus_in.sel,
                           bus_in.dbp};
      IDX_FLAGS:     rd = {s.dma_finished_flag, 1'b0, s.parity_fault_flag, s.interrupt_active_flag, peq, s.busy_loss_flag,
                           bus_in.atn, bus_in.ack};
      IDX_HIGH_ID:   rd = {bus_in.hid, 5'b00000};
      default:       rd = 8'h00;
    endcase
    // Read data is caught in the setup cycle so prdata comes from a flop
    if (setup & ~pwrite) begin
      next_s.rdata = {24'h00_0000, hit ? rd : 8'h00};
    end

    if (acc & pwrite & hit) begin
      unique case (idx)
        IDX_OUT_BYTE:  next_s.out_byte = pwdata[7:0];
        IDX_INIT_CTRL: begin
          next_s.ctrl_rst = pwdata[CTRL_RST];
          next_s.ctrl     = pwdata[4:0];
        end
        IDX_MODE: begin
          next_s.mode = pwdata[7:0] & MODE_WMASK;
          // DMA can only be switched on while busy is seen
          if (~bus_in.bsy & ~s.mode[MODE_DMA]) begin
            next_s.mode[MODE_DMA] = 1'b0;
          end
        end
        IDX_TPHASE:    next_s.tphase = pwdata[3:0];
        IDX_LIVE_BUS:  next_s.sel_mask = pwdata[7:0];
        IDX_HIGH_MASK: next_s.hid_mask = pwdata[7:HID_LSB];
        default: ;
      endcase
    end
    if (acc & ~pwrite & hit & (idx == IDX_CLR)) begin
      next_s.parity_fault_flag = 1'b0;
      next_s.interrupt_active_flag  = 1'b0;
      next_s.busy_loss_flag = 1'b0;
    end

    // Strobes: send in either role, receives need the matching role
    if (send_go
        | (start_ok & (idx == IDX_TGT_RX) & tgt)
        | (start_ok & (idx == IDX_CLR) & ~tgt)) begin
      next_s.xf         = X_LOAD;
      next_s.x_send     = send_go;
      next_s.x_tgt      = tgt;
      next_s.final_sent = 1'b0;
      next_s.dma_finished_flag        = 1'b0;
      next_s.own        = 1'b0;
    end

    // Automatic REQ/ACK handshake while DMA is on
    unique case (s.xf)
      X_IDLE: ;
      X_LOAD: begin
        if (s.x_tgt) begin
          if (~s.x_send | dma_tx_valid) begin
            dma_tx_ready = s.x_send;
            if (s.x_send) begin
              next_s.x_byte = dma_tx_data;
              next_s.x_last = dma_last;
              next_s.dma_finished_flag    = dma_last;
            end
            next_s.own = 1'b1;
            next_s.xf  = X_HOLD;
          end
        end else if (bus_in.req & peq & known_ph
                     & (~s.x_send | dma_tx_valid)) begin
          dma_tx_ready    = s.x_send;
          next_s.x_last   = dma_last;
          next_s.dma_finished_flag      = dma_last;
          if (s.x_send) begin
            next_s.x_byte = dma_tx_data;
          end else begin
            next_s.rx_valid = 1'b1;
            next_s.rx_data  = bus_in.db;
          end
          next_s.own = 1'b1;
          next_s.xf  = X_HOLD;
        end
      end
      X_HOLD: begin
        if (s.x_tgt & bus_in.ack) begin
          if (~s.x_send) begin
            next_s.rx_valid = 1'b1;
            next_s.rx_data  = bus_in.db;
            next_s.x_last   = dma_last;
            next_s.dma_finished_flag      = dma_last;
          end
          next_s.own = 1'b0;
          next_s.xf  = X_TAIL;
        end else if (~s.x_tgt & ~bus_in.req) begin
          next_s.own = 1'b0;
          next_s.xf  = s.x_last ? X_IDLE : X_LOAD;
          if (s.x_last & s.x_send) begin
            next_s.final_sent = 1'b1;
          end
        end
      end
      X_TAIL: begin
        if (~bus_in.ack) begin
          next_s.xf = s.x_last ? X_IDLE : X_LOAD;
        end
      end
    endcase

    // Parity on received bytes and on selection
    if (s.mode[MODE_PCHK] & bad_par
        & (next_s.rx_valid | (selm & ~s.selm_q))) begin
      next_s.parity_fault_flag = 1'b1;
      if (s.mode[MODE_EPI]) begin
        next_s.interrupt_active_flag = 1'b1;
      end
    end
    if (selm & ~s.selm_q) begin
      next_s.interrupt_active_flag = 1'b1;
    end
    if (~tgt & s.mode[MODE_DMA] & bus_in.req & ~s.req_q & ~peq) begin
      next_s.interrupt_active_flag = 1'b1;
    end

    // Arbitration
    if (~next_s.mode[MODE_ARB]) begin
      next_s.arbitrate_bit      = ARB_OFF;
      next_s.arb_lost = 1'b0;
    end else begin
      unique case (s.arbitrate_bit)
        ARB_OFF:  next_s.arbitrate_bit = ARB_WAIT;
        ARB_WAIT: if (~bus_in.bsy & ~bus_in.sel) begin
          next_s.arbitrate_bit = ARB_ON;
        end
        ARB_ON:   if (bus_in.sel & ~s.ctrl[CTRL_SEL]) begin
          next_s.arb_lost = 1'b1;
        end
      endcase
    end

    // A transfer end leaves the DMA bit on; only mode writes and busy loss clear it
    if (~next_s.mode[MODE_DMA]) begin
      next_s.dma_finished_flag = 1'b0;
      next_s.xf  = X_IDLE;
      next_s.own = 1'b0;
    end

    // Busy loss has the last word over every other update
    if (busy_evt) begin
      next_s.busy_loss_flag           = 1'b1;
      next_s.interrupt_active_flag            = 1'b1;
      next_s.ctrl           = CTRL_RESET[4:0];
      next_s.arb_lost       = 1'b0;
      next_s.mode[MODE_DMA] = 1'b0;
      next_s.dma_finished_flag            = 1'b0;
      next_s.xf             = X_IDLE;
      next_s.own            = 1'b0;
    end
  end

  // Mode, target phase and control start from their package reset values; all other fields start from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.mode     <= MODE_RESET;
      s.tphase   <= TPHASE_RESET;
      s.ctrl     <= CTRL_RESET[4:0];
      s.arbitrate_bit      <= ARB_OFF;
      s.xf       <= X_IDLE;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Data lines follow the DMA byte only while a send transfer is not idle
  logic kill, xsend_act;
  assign kill      = s.busy_loss_flag;
  assign xsend_act = (s.xf != X_IDLE) & s.x_send;

  // Outputs are released while the busy error stands
  always_comb begin
    bus_oe      = '0;
    bus_db_out  = xsend_act ? s.x_byte : s.out_byte;
    bus_dbp_out = ~^bus_db_out;
    if (~kill) begin
      bus_oe.rst = s.ctrl_rst;
      bus_oe.bsy = s.ctrl[CTRL_BSY] | (s.arbitrate_bit == ARB_ON);
      bus_oe.sel = s.ctrl[CTRL_SEL];
      bus_oe.atn = s.ctrl[CTRL_ATN] & ~tgt;
      bus_oe.ack = ~tgt & (s.ctrl[CTRL_ACK] | s.own);
      // Request bit has no meaning for an initiator
      bus_oe.req = tgt & (s.tphase[TP_REQ] | s.own);
      bus_oe.msg = tgt & s.tphase[2];
      bus_oe.cd  = tgt & s.tphase[1];
      bus_oe.io  = tgt & s.tphase[0];
      bus_oe.db  = (s.arbitrate_bit == ARB_ON)
                 | (s.ctrl[CTRL_DRV] & (tgt | (~bus_in.io & peq)));
    end
  end

  // Read data and received bytes come straight from flops
  assign prdata       = s.rdata;
  assign dma_rx_valid = s.rx_valid;
  assign dma_rx_data  = s.rx_data;
  assign irq          = s.interrupt_active_flag;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  sequence busy_drop;
    s.mode[MODE_WATCH] && s.bsy_q && !bus_in.bsy;
  endsequence

  a_busy_loss_flag: assert property (busy_drop |=> s.busy_loss_flag && irq
      && !s.mode[MODE_DMA] && s.ctrl == 5'b00000)
    else $error("busy loss did not set flag and clear state");
  a_busy_release: assert property (s.busy_loss_flag |-> bus_oe == '0)
    else $error("outputs driven after busy loss");
  a_dma_sticky: assert property (s.mode[MODE_DMA] && !mode_wr
      && !busy_evt |=> s.mode[MODE_DMA])
    else $error("DMA bit dropped without write");
  a_phase_read: assert property (setup && !pwrite && hit
      && idx == IDX_FLAGS |=> prdata[FL_PEQ] == $past(peq))
    else $error("phase equal flag wrong");
  a_clear_read: assert property (acc && !pwrite && hit
      && idx == IDX_CLR && !busy_evt && !selm
      && !bus_in.req |=> !irq && !s.parity_fault_flag)
    else $error("clear read did not drop flags");
  a_sel_int: assert property (selm && !s.selm_q |=> irq)
    else $error("selection did not interrupt");
  a_init_drive: assert property (!tgt |-> !bus_oe.req && !bus_oe.msg
      && !bus_oe.cd && !bus_oe.io)
    else $error("phase lines driven as initiator");
  a_final_byte: assert property (!s.final_sent && !(s.xf == X_HOLD
      && !s.x_tgt && s.x_send && s.x_last) |=> !s.final_sent)
    else $error("final byte flag without last send");
  a_eod_clear: assert property (!s.mode[MODE_DMA] |-> !s.dma_finished_flag)
    else $error("finished flag stands with DMA off");
  a_parity_fault_flag_gate: assert property (!s.parity_fault_flag && !s.mode[MODE_PCHK]
      |=> !s.parity_fault_flag)
    else $error("parity fault without checking");
  a_mismatch: assert property (!tgt && s.mode[MODE_DMA] && bus_in.req
      && !s.req_q && !peq |=> irq)
    else $error("phase mismatch missed");
  a_send_start: assert property (send_go && !busy_evt
      |=> s.xf == X_LOAD && s.x_send)
    else $error("send strobe did not start");
  // Arbitration must not claim the bus while it is still in use
  a_arb_free: assert property (s.arbitrate_bit == ARB_WAIT
      && (bus_in.bsy || bus_in.sel) |=> s.arbitrate_bit != ARB_ON)
    else $error("arbitration started on a busy bus");
  // A receive strobe in the wrong role leaves the transfer idle
  a_role_gate: assert property (acc && pwrite && hit && !tgt
      && idx == IDX_TGT_RX && s.xf == X_IDLE |=> s.xf == X_IDLE)
    else $error("target receive started as initiator");

endmodule : scsi_bus_phase_control

`default_nettype wire

// File: verif/scsi_far_end.sv
// Far-side SCSI device model: wire-OR bus and initiator ACK reply
`default_nettype none

module scsi_far_end
  import scsi_phase_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire scsi_in_t   drv,
  input  wire logic [3:0] lag,
  input  wire scsi_oe_t   oe,
  input  wire logic [7:0] db_out,
  input  wire logic       dbp_out,
  output var  scsi_in_t   bus,
  output var  logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt;
  logic       ack_q;

  // ACK answers REQ lag+1 cycles later, so both quick and slow peers are seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt   <= 4'h0;
      ack_q <= 1'b0;
      got   <= 8'h00;
    end else if (!bus.req) begin
      cnt   <= 4'h0;
      ack_q <= 1'b0;
    end else if (cnt < lag) begin
      cnt <= cnt + 4'h1;
    end else if (!ack_q) begin
      ack_q <= 1'b1;
      got   <= bus.db;
    end
  end

  // Released lines fall to the terminated, deasserted level
  always_comb begin
    bus     = drv;
    bus.rst = drv.rst | oe.rst;
    bus.bsy = drv.bsy | oe.bsy;
    bus.sel = drv.sel | oe.sel;
    bus.atn = drv.atn | oe.atn;
    bus.ack = drv.ack | oe.ack | ack_q;
    bus.req = drv.req | oe.req;
    bus.msg = drv.msg | oe.msg;
    bus.cd  = drv.cd | oe.cd;
    bus.io  = drv.io | oe.io;
    bus.db  = drv.db | (oe.db ? db_out : 8'h00);
    bus.dbp = drv.dbp | (oe.db & dbp_out);
  end
endmodule : scsi_far_end

`default_nettype wire

// File: verif/scsi_bus_phase_control_tb.sv
// Self-checking bench of the SCSI bus phase core
`default_nettype none

module scsi_bus_phase_control_tb
  import scsi_phase_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  scsi_in_t          bus_in;
  scsi_in_t          drv = '0;
  scsi_oe_t          bus_oe;
  logic [7:0]        db_out;
  logic              dbp_out;
  logic              tx_valid = 1'b0;
  logic [7:0]        tx_data = 8'h00;
  logic              tx_last = 1'b0;
  logic              tx_ready;
  logic              rx_valid;
  logic [7:0]        rx_data;
  logic              irq;
  logic [3:0]        lag = 4'h1;
  logic [7:0]        got;
  int                miscompares = 0;
  int                checks = 0;

  always #4 pclk = ~pclk;

  scsi_bus_phase_control dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_in(bus_in),
    .bus_oe(bus_oe), .bus_db_out(db_out), .bus_dbp_out(dbp_out),
    .dma_tx_valid(tx_valid), .dma_tx_data(tx_data), .dma_last(tx_last),
    .dma_tx_ready(tx_ready), .dma_rx_valid(rx_valid),
    .dma_rx_data(rx_data), .irq(irq)
  );

  scsi_far_end far (
    .pclk(pclk), .presetn(presetn), .drv(drv), .lag(lag), .oe(bus_oe),
    .db_out(db_out), .dbp_out(dbp_out), .bus(bus_in), .got(got)
  );

  task automatic end_sim;
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic tmo;
    $display("[ERR] %0t wait ran out", $time);
    miscompares++;
    end_sim();
  endtask : tmo

  task automatic xfer(input logic w, input logic [15:0] i,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {i, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q   = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) tmo();
  endtask : xfer

  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic       e;
    xfer(1'b1, i, d, q, e);
  endtask : wr

  task automatic rc(input logic [15:0] i, input logic [7:0] m,
                    input logic [7:0] e);
    logic [7:0] q;
    logic       er;
    xfer(1'b0, i, 8'h00, q, er);
    chk(q & m, e);
  endtask : rc

  // Far side lines in live-bus order, then data and high ID
  task automatic put(input logic [7:0] c, input logic [7:0] d,
                     input logic [2:0] h);
    @(posedge pclk);
    drv <= scsi_in_t'({c, 2'b00, d, h});
    repeat (4) @(posedge pclk);
  endtask : put

  task automatic wirq;
    int n;
    for (n = 0; n < 20 && irq !== 1'b1; n++) @(posedge pclk);
    chk({7'h00, irq}, 8'h01);
  endtask : wirq

  task automatic send(input logic [7:0] d, input logic l);
    int n;
    tx_valid <= 1'b1;
    tx_data  <= d;
    tx_last  <= l;
    for (n = 0; n < 60; n++) begin
      @(negedge pclk);
      if (tx_ready === 1'b1) break;
    end
    @(posedge pclk);
    if (n == 60) tmo();
  endtask : send

  task automatic t_regs;
    logic [7:0] q;
    logic       e;
    rc(IDX_MODE, 8'hff, MODE_RESET);
    rc(IDX_TPHASE, 8'hff, 8'h00);
    xfer(1'b0, 16'hfc09, 8'h00, q, e);
    chk({7'h00, e}, 8'h01);
    chk(q, 8'h00);
    put(8'haa, 8'h00, 3'b101);
    rc(IDX_HIGH_ID, 8'he0, 8'ha0);
    rc(IDX_LIVE_BUS, 8'hff, 8'haa);
    put(8'h55, 8'h00, 3'b000);
    rc(IDX_LIVE_BUS, 8'hff, 8'h55);
  endtask : t_regs

  task automatic t_phase;
    phase_t ph [6];
    ph = '{PH_DATA_OUT, PH_COMMAND, PH_MSG_OUT,
           PH_DATA_IN, PH_STATUS, PH_MSG_IN};
    foreach (ph[k]) begin
      wr(IDX_TPHASE, {5'h00, ph[k]});
      put({3'b000, ph[k], 2'b00}, 8'h00, 3'b000);
      rc(IDX_FLAGS, 8'h08, 8'h08);
      put({3'b000, ph[k] ^ 3'b100, 2'b00}, 8'h00, 3'b000);
      rc(IDX_FLAGS, 8'h08, 8'h00);
    end
  endtask : t_phase

  task automatic t_target;
    wr(IDX_MODE, 8'h40);
    wr(IDX_TPHASE, 8'h0f);
    @(negedge pclk);
    chk({4'h0, bus_oe.req, bus_oe.msg, bus_oe.cd, bus_oe.io}, 8'h0f);
    wr(IDX_MODE, 8'h00);
    @(negedge pclk);
    chk({4'h0, bus_oe.req, bus_oe.msg, bus_oe.cd, bus_oe.io}, 8'h00);
    wr(IDX_INIT_CTRL, 8'h02);
    @(negedge pclk);
    chk({7'h00, bus_oe.atn}, 8'h01);
    wr(IDX_MODE, 8'h40);
    @(negedge pclk);
    chk({7'h00, bus_oe.atn}, 8'h00);
    wr(IDX_MODE, 8'h00);
    wr(IDX_INIT_CTRL, 8'h00);
    wr(IDX_TPHASE, 8'h00);
  endtask : t_target

  task automatic t_select;
    wr(IDX_LIVE_BUS, 8'h04);
    put(8'h02, 8'h04, 3'b000);
    wirq();
    rc(IDX_FLAGS, 8'h30, 8'h10);
    rc(IDX_CLR, 8'h00, 8'h00);
    rc(IDX_FLAGS, 8'h10, 8'h00);
    chk({7'h00, irq}, 8'h00);
    put(8'h00, 8'h00, 3'b000);
    wr(IDX_LIVE_BUS, 8'h00);
    wr(IDX_HIGH_MASK, 8'h20);
    put(8'h03, 8'h00, 3'b001);
    wirq();
    put(8'h00, 8'h00, 3'b000);
    rc(IDX_CLR, 8'h00, 8'h00);
    wr(IDX_HIGH_MASK, 8'h00);
    put(8'h03, 8'hff, 3'b111);
    rc(IDX_FLAGS, 8'h10, 8'h00);
    put(8'h00, 8'h00, 3'b000);
    // Bad parity during selection
    wr(IDX_MODE, 8'h20);
    wr(IDX_LIVE_BUS, 8'h04);
    put(8'h03, 8'h04, 3'b000);
    put(8'h00, 8'h00, 3'b000);
    rc(IDX_FLAGS, 8'h20, 8'h20);
    rc(IDX_CLR, 8'h00, 8'h00);
    rc(IDX_FLAGS, 8'h20, 8'h00);
    wr(IDX_MODE, 8'h00);
    put(8'h03, 8'h04, 3'b000);
    put(8'h00, 8'h00, 3'b000);
    rc(IDX_FLAGS, 8'h20, 8'h00);
    rc(IDX_CLR, 8'h00, 8'h00);
    wr(IDX_LIVE_BUS, 8'h00);
  endtask : t_select

  task automatic t_busy;
    wr(IDX_MODE, 8'h02);
    rc(IDX_MODE, 8'h02, 8'h00);
    put(8'h40, 8'h00, 3'b000);
    wr(IDX_MODE, 8'h06);
    rc(IDX_MODE, 8'h02, 8'h02);
    wr(IDX_INIT_CTRL, 8'h03);
    put(8'h00, 8'h00, 3'b000);
    wirq();
    rc(IDX_FLAGS, 8'h04, 8'h04);
    rc(IDX_MODE, 8'h02, 8'h00);
    rc(IDX_INIT_CTRL, 8'h3f, 8'h00);
    chk({7'h00, |bus_oe}, 8'h00);
    wr(IDX_MODE, 8'h00);
    rc(IDX_CLR, 8'h00, 8'h00);
    rc(IDX_FLAGS, 8'h14, 8'h00);
  endtask : t_busy

  task automatic t_send;
    int n;
    put(8'h40, 8'h00, 3'b000);
    lag <= 4'h5;
    wr(IDX_MODE, 8'h42);
    wr(IDX_TPHASE, 8'h01);
    wr(IDX_INIT_CTRL, 8'h01);
    wr(IDX_FLAGS, 8'h00);
    send(8'h5a, 1'b0);
    send(8'hc3, 1'b1);
    chk(got, 8'h5a);
    tx_valid <= 1'b0;
    for (n = 0; n < 60 && (got !== 8'hc3 || bus_in.ack); n++)
      @(posedge pclk);
    chk(got, 8'hc3);
    rc(IDX_FLAGS, 8'h80, 8'h80);
    rc(IDX_MODE, 8'h02, 8'h02);
    wr(IDX_MODE, 8'h40);
    rc(IDX_FLAGS, 8'h80, 8'h00);
    wr(IDX_INIT_CTRL, 8'h00);
    wr(IDX_TPHASE, 8'h00);
  endtask : t_send

  task automatic t_mismatch;
    wr(IDX_MODE, 8'h02);
    put(8'h64, 8'h00, 3'b000);
    wirq();
    put(8'h40, 8'h00, 3'b000);
    wr(IDX_MODE, 8'h00);
    rc(IDX_CLR, 8'h00, 8'h00);
    put(8'h00, 8'h00, 3'b000);
  endtask : t_mismatch

  task automatic t_init;
    put(8'h40, 8'h00, 3'b000);
    wr(IDX_MODE, 8'h02);
    wr(IDX_TPHASE, 8'h00);
    wr(IDX_INIT_CTRL, 8'h01);
    wr(IDX_FLAGS, 8'h00);
    drv <= scsi_in_t'({8'h60, 2'b00, 8'h00, 3'b000});
    send(8'h3c, 1'b1);
    tx_valid <= 1'b0;
    @(negedge pclk);
    chk(bus_in.db, 8'h3c);
    chk({7'h00, bus_oe.ack}, 8'h01);
    put(8'h40, 8'h00, 3'b000);
    rc(IDX_TPHASE, 8'h80, 8'h80);
    wr(IDX_TPHASE, 8'h01);
    wr(IDX_CLR, 8'h00);
    put(8'h64, 8'h77, 3'b000);
    put(8'h40, 8'h00, 3'b000);
    chk(rx_data, 8'h77);
    wr(IDX_MODE, 8'h00);
    wr(IDX_INIT_CTRL, 8'h00);
    wr(IDX_TPHASE, 8'h00);
    rc(IDX_CLR, 8'h00, 8'h00);
    put(8'h00, 8'h00, 3'b000);
  endtask : t_init

  task automatic t_arb;
    logic [7:0] q;
    logic       e;
    int         n;
    wr(IDX_OUT_BYTE, 8'h01);
    wr(IDX_MODE, 8'h01);
    for (n = 0; n < 20; n++) begin
      xfer(1'b0, IDX_INIT_CTRL, 8'h00, q, e);
      if (q[6] === 1'b1) break;
    end
    chk(q & 8'h40, 8'h40);
    wr(IDX_MODE, 8'h00);
    rc(IDX_INIT_CTRL, 8'h40, 8'h00);
  endtask : t_arb

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_phase();
    t_target();
    t_select();
    t_busy();
    t_send();
    t_mismatch();
    t_init();
    t_arb();
    end_sim();
  end
endmodule : scsi_bus_phase_control_tb

`default_nettype wire
